// *** rtl/aov_accum.sv ***
// Purpose: One 25-bit sample accumulator placed in a 32-bit result word
// Assumes: Samples are 14-bit codes; 11-bit codes arrive already right aligned
// Notes: Sum wraps silently; overflow of results is flagged elsewhere
`timescale 1ns/1ns
`default_nettype none
module aov_accum (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic clear,
  input wire aov_pkg::aov_sample_t sample,
  // Result
  output logic [31:0] word_q
);
  logic [aov_pkg::SUM_W-1:0] sum_q;
  logic [aov_pkg::SUM_W-1:0] step;

  // Eleven-bit counts weigh eight, low bits stay zero
  assign step = sample.res11 ?
    aov_pkg::SUM_W'({sample.code, 3'h0}) : aov_pkg::SUM_W'(sample.code);

  // Running sum of converter codes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sum_q <= '0;
    end else if (clear) begin
      sum_q <= '0;
    end else if (sample.valid) begin
      sum_q <= sum_q + step;
    end
  end

  // Low seven bits read as zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      word_q <= aov_pkg::ACC_RST;
    end else begin
      word_q <= {sum_q, 7'h00};
    end
  end
endmodule : aov_accum
`default_nettype wire

// *** rtl/aov_bank.sv ***
// Purpose: Read-only bank of bus and sense accumulators plus overflow flags
// Assumes: Byte register port driven by the serial management front end
// Notes: Readback freezes in the read state so a multi-byte read is coherent
//
// Summary of operation
// RULE_01: Sense sum is 25 bits in word bits 31:7, zero at reset.
// RULE_02: One sum step equals one 14-bit converter code.
// RULE_03: At 11-bit resolution sense counts are shifted left three places.
// RULE_04: At 11-bit resolution bus counts weigh eight; low three bits zero.
// RULE_05: Sums are valid only in read state; host reads only then.
// RULE_06: Low seven bits of each accumulator word read as zero.
// RULE_07: Status bit 2 set when current gain overflows sense result.
// RULE_08: Status bit 1 set when voltage gain overflows bus result.
// RULE_09: Status bit 0 set when either gain overflows power result.
// RULE_10: Status bits 7 to 3 read as zero.
// RULE_11: Accumulator bytes most significant first at lowest address; writes ignored.
`timescale 1ns/1ns
`default_nettype none
module aov_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Measurement phase
  input wire logic integrate,
  input wire logic read_phase,
  // Converter samples
  input wire aov_pkg::aov_sample_t bus_sample,
  input wire aov_pkg::aov_sample_t sense_sample,
  // Overflow events from the result path
  input wire logic sense_ovf_evt,
  input wire logic bus_ovf_evt,
  input wire logic power_ovf_evt,
  // Register port
  input wire aov_pkg::aov_req_t req,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output logic sums_valid_q
);
  aov_pkg::aov_state_t state_q, state_d;
  logic [31:0] bus_word;
  logic [31:0] sense_word;
  logic [31:0] bus_hold_q;
  logic [31:0] sense_hold_q;
  logic [2:0] ovf_q;
  logic clear_sums;
  logic enter_read;
  logic [7:0] sel_byte;
  logic [7:0] rel_bus;
  logic [7:0] rel_sense;
  logic hit_bus;
  logic hit_sense;
  logic hit_ovf;

  // Phase machine; a new integration restarts both sums
  always_comb begin
    state_d = state_q;
    case (state_q)
      aov_pkg::ST_IDLE: if (integrate) state_d = aov_pkg::ST_INTEGRATE;
      aov_pkg::ST_INTEGRATE: if (read_phase) state_d = aov_pkg::ST_READ;
      aov_pkg::ST_READ: if (integrate) state_d = aov_pkg::ST_INTEGRATE;
      default: state_d = aov_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= aov_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign clear_sums = integrate && (state_q != aov_pkg::ST_INTEGRATE);
  assign enter_read = (state_d == aov_pkg::ST_READ) && (state_q != aov_pkg::ST_READ);

  // Two accumulators share one structure
  aov_accum u_bus_acc (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(clear_sums),
    .sample(bus_sample),   // [RULE_02] [RULE_04]
    .word_q(bus_word)
  );

  aov_accum u_sense_acc (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(clear_sums),
    .sample(sense_sample), // [RULE_02] [RULE_03]
    .word_q(sense_word)    // [RULE_01] [RULE_06]
  );

  // Copies track the words through integrate state, last taken on entry to read state; accumulator keeps running is not a hazard
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_hold_q <= aov_pkg::ACC_RST;
      sense_hold_q <= aov_pkg::ACC_RST; // [RULE_01]
    end else if (state_q == aov_pkg::ST_INTEGRATE) begin
      bus_hold_q <= bus_word;
      sense_hold_q <= sense_word;
    end
  end

  // Sticky overflow flags; an event beats the restart clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovf_q <= aov_pkg::OVF_RST[2:0];
    end else begin
      ovf_q[aov_pkg::SENSE_OVF_BIT] <= sense_ovf_evt ||
        (ovf_q[aov_pkg::SENSE_OVF_BIT] && !clear_sums);  // [RULE_07]
      ovf_q[aov_pkg::BUS_OVF_BIT] <= bus_ovf_evt ||
        (ovf_q[aov_pkg::BUS_OVF_BIT] && !clear_sums);    // [RULE_08]
      ovf_q[aov_pkg::POWER_OVF_BIT] <= power_ovf_evt ||
        (ovf_q[aov_pkg::POWER_OVF_BIT] && !clear_sums);  // [RULE_09]
    end
  end

  // Address decode; byte 0 of each word is its top byte
  assign rel_bus = req.addr - aov_pkg::BUS_ACC_OFS;
  assign rel_sense = req.addr - aov_pkg::SENSE_ACC_OFS;
  assign hit_bus = (req.addr >= aov_pkg::BUS_ACC_OFS) && (rel_bus < 8'h04);
  assign hit_sense = (req.addr >= aov_pkg::SENSE_ACC_OFS) && (rel_sense < 8'h04);
  assign hit_ovf = (req.addr == aov_pkg::OVF_FLAGS_OFS);

  always_comb begin
    if (hit_bus) begin
      sel_byte = bus_hold_q[(8'h03 - rel_bus[1:0]) * 8 +: 8];     // [RULE_11]
    end else if (hit_sense) begin
      sel_byte = sense_hold_q[(8'h03 - rel_sense[1:0]) * 8 +: 8]; // [RULE_11]
    end else if (hit_ovf) begin
      sel_byte = {5'h00, ovf_q};                                  // [RULE_10]
    end else begin
      sel_byte = 8'h00;
    end
  end

  // Read data registered; writes have no effect at all
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      sums_valid_q <= 1'b0;
    end else begin
      rdata_q <= req.rd ? sel_byte : 8'h00; // [RULE_11]
      rvalid_q <= req.rd;
      sums_valid_q <= (state_d == aov_pkg::ST_READ) && !enter_read ||
        (state_q == aov_pkg::ST_READ && state_d == aov_pkg::ST_READ); // [RULE_05]
    end
  end
endmodule : aov_bank
`default_nettype wire

// *** rtl/aov_pkg.sv ***
// Purpose: Shared constants and carriers for the accumulator and overflow result bank
// Assumes: Byte-wide register port, offsets are byte addresses
// Notes: Accumulators are big-endian across four byte addresses
package aov_pkg;
  localparam logic [7:0] BUS_ACC_OFS = 8'h14;
  localparam logic [7:0] SENSE_ACC_OFS = 8'h18;
  localparam logic [7:0] OVF_FLAGS_OFS = 8'h1c;
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [7:0] OVF_RST = 8'h00;
  localparam int SUM_W = 25;
  localparam int SUM_LSB = 7;
  localparam int RES11_SHIFT = 3;
  localparam int SENSE_OVF_BIT = 2;
  localparam int BUS_OVF_BIT = 1;
  localparam int POWER_OVF_BIT = 0;

  // One converter sample with its valid flag, code and resolution
  typedef struct packed {
    logic valid;
    logic [13:0] code;
    logic res11;
  } aov_sample_t;

  // Byte read or write request from the serial management side
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aov_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_INTEGRATE = 3'b010,
    ST_READ = 3'b100
  } aov_state_t;
endpackage : aov_pkg

// *** tb/aov_checker.sv ***
// Purpose: Port checks of the result bank
// Assumes: One clock, async high reset
// Notes: Flag checks need no restart between event and read
`timescale 1ns/1ns
`default_nettype none
module aov_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Watched ports
  input wire logic integrate,
  input wire logic sense_ovf_evt,
  input wire logic bus_ovf_evt,
  input wire logic power_ovf_evt,
  input wire aov_pkg::aov_req_t req,
  input wire logic [7:0] rdata_q,
  input wire logic rvalid_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Read kinds
  wire fl = req.rd && req.addr == 8'h1c && !integrate;
  wire lo = req.rd && (req.addr == 8'h17 || req.addr == 8'h1b);
  wire um = req.rd && (req.addr < 8'h14 || req.addr > 8'h1c);
  a_read_answer: assert property (req.rd |=> rvalid_q) else $error("no answer");
  a_no_extra: assert property (!req.rd |=> !rvalid_q) else $error("extra");
  a_idle_zero: assert property (!rvalid_q |-> rdata_q == 8'h00) else $error("stale");
  a_flag_upper: assert property (fl |=> rdata_q[7:3] == 5'h00) else $error("upper");
  a_acc_low: assert property (lo |=> rdata_q[6:0] == 7'h00) else $error("low");
  a_unmapped_zero: assert property (um |=> rdata_q == 8'h00) else $error("unmap");
  a_sense_flag: assert property (sense_ovf_evt ##1 fl |=> rdata_q[2]) else $error("s");
  a_bus_flag: assert property (bus_ovf_evt ##1 fl |=> rdata_q[1]) else $error("b");
  a_power_flag: assert property (power_ovf_evt ##1 fl |=> rdata_q[0]) else $error("p");
endmodule : aov_checker
bind aov_bank aov_checker CHK (.ref_clk, .rst, .integrate, .sense_ovf_evt, .bus_ovf_evt,
  .power_ovf_evt, .req, .rdata_q, .rvalid_q);
`default_nettype wire

// *** tb/aov_host.sv ***
// Purpose: Host side issuing byte accesses
// Assumes: One access at a time
// Notes: Address scrambled once released
`timescale 1ns/1ns
`default_nettype none
module aov_host (
  // Clock
  input wire logic ref_clk,
  // Request
  output var aov_pkg::aov_req_t req
);
  initial req = '0;
  // One-cycle access
  task automatic acc(input logic w, input logic [7:0] a);
    @(negedge ref_clk);
    req = '{!w, w, a, ~a};
    @(negedge ref_clk);
    req = '{1'b0, 1'b0, ~a, a};
  endtask : acc
endmodule : aov_host
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Bench for the result bank
// Assumes: Flags read live
// Notes: Answers matched in request order
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic integrate = 1'b0;
  logic read_phase = 1'b0;
  logic [2:0] evt = 3'h0;
  aov_pkg::aov_sample_t bs = '0;
  aov_pkg::aov_sample_t ss = '0;
  aov_pkg::aov_req_t req;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic sums_valid_q;
  logic [7:0] expq[$];
  logic [31:0] sd = 32'hc02d;
  logic [24:0] bsum;
  logic [24:0] ssum;
  int err_count = 0;
  int comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  aov_bank DUT (.ref_clk, .rst, .integrate, .read_phase, .bus_sample(bs), .sense_sample(ss),
    .sense_ovf_evt(evt[2]), .bus_ovf_evt(evt[1]), .power_ovf_evt(evt[0]), .req, .rdata_q,
    .rvalid_q, .sums_valid_q);
  aov_host HOST (.ref_clk, .req);
  // Xorshift step for the random sample stream
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Readback validity level against its expected state
  task automatic chk_lvl(input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] sums_valid exp %b got %b", e, g);
    end
  endtask : chk_lvl
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] rdata exp %h got %h", e, g);
    end
  endtask : chk
  // Note the answer, then ask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    HOST.acc(1'b0, a);
  endtask : rd
  task automatic rw(input logic [7:0] a, input logic [24:0] s);
    for (int i = 0; i < 4; i++) rd(a + 8'(i), 8'({s, 7'h00} >> (24 - 8 * i)));
  endtask : rw
  // Random sample, 11-bit codes kept to 11 bits
  function automatic aov_pkg::aov_sample_t smp(input logic [15:0] r);
    return '{1'b1, {r[14] ? 3'h0 : r[13:11], r[10:0]}, r[14]};
  endfunction : smp
  // Oldest note against each answer
  always @(negedge ref_clk) if (rvalid_q === 1'b1) chk(expq.pop_front(), rdata_q);
  task automatic run(input logic [2:0] ev);
    bsum = '0;
    ssum = '0;
    @(negedge ref_clk) integrate = 1'b1;
    @(negedge ref_clk) integrate = 1'b0;
    repeat (12) begin
      sd = xs(sd);
      bs = smp(sd[15:0]);
      ss = smp(sd[31:16]);
      bsum += 25'(bs.code) << (bs.res11 ? 3 : 0);
      ssum += 25'(ss.code) << (ss.res11 ? 3 : 0);
      @(negedge ref_clk);
    end
    chk_lvl(1'b0, sums_valid_q);
    bs = '0;
    ss = '0;
    evt = ev;
    fork
      rd(8'h1c, {5'h00, ev});
      @(negedge ref_clk) evt = 3'h0;
    join
    read_phase = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk_lvl(1'b1, sums_valid_q);
    rw(8'h14, bsum);
    rw(8'h18, ssum);
    HOST.acc(1'b1, 8'h18);
    rd(8'h18, 8'(ssum >> 17));
    rd(8'h13, 8'h00);
    rd(8'h1d, 8'h00);
    read_phase = 1'b0;
  endtask : run
  task automatic final_report;
    // A read that never got its answer leaves a note behind
    if (expq.size() != 0) err_count++;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    run(3'h5);
    run(3'h2);
    repeat (3) @(negedge ref_clk);
    final_report();
  end
  // Hang guard
  initial begin
    #20000;
    err_count++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
